//--- rtl/flash_rdmode_defines.svh
// constants for the per-partition read-mode command block
//----------------------------------------------------------------
// Behaviour
//----------------------------------------------------------------
// Behaviour
// - reset puts every partition in array mode
// - one write selects mode: FF, 70, 90
// - array command affects addressed partition only
// - program, erase or lock setup forces status
// - array read of busy partition gives invalid
// - resume after suspend returns partition to status
// - read-mode commands ignore program supply level
// - identification mode returns codes, locks, otp, config
// - offsets 02h lock bits, 05h/06h config registers
// - offsets 80h-109h return otp locks and data
// - id mode kept until command or operation
// - id on busy partition withholds data until done
// - query 98h mode until command or operation
// - query on busy partition gives invalid data
// - status command affects addressed partition only
// - status word refreshed only on select toggle
// - sync read wait marks invalid, moves on edges
// - wait polarity defaults to active low
// - wait deasserted in async reads, off deselected
// - wait off or deasserted per bus variant
// - read mode bit defaults to asynchronous
// - polarity bit and wait delay bit honoured
`ifndef FLASH_RDMODE_DEFINES_SVH
`define FLASH_RDMODE_DEFINES_SVH
// command codes
`define CMD_ARRAY   16'h00FF
`define CMD_STATUS  16'h0070
`define CMD_ID      16'h0090
`define CMD_CFI     16'h0098
// register byte offsets
`define OFS_CTRL    6'h00
`define OFS_RCR     6'h04
`define OFS_ECR     6'h08
`define OFS_MODE    6'h0C
`define OFS_RDST    6'h10
// reset values and field positions
`define RCR_RST     16'h8000
`define ECR_RST     16'h0004
`define RCR_MODE    15
`define RCR_LAT_HI  14
`define RCR_LAT_LO  11
`define RCR_POL     10
`define RCR_DLY     8
`define CTRL_MUX    0
// identification offsets
`define ID_MAKER    9'h000
`define ID_DEV      9'h001
`define ID_LOCK     9'h002
`define ID_RCR      9'h005
`define ID_ECR      9'h006
`define ID_OTPL0    9'h080
`define ID_OTPF_HI  9'h084
`define ID_OTPU_HI  9'h088
`define ID_OTPL1    9'h089
`define ID_OTP_END  9'h109
`endif

//--- rtl/flash_rdmode_pkg.sv
// types shared by the read-mode command block
package flash_rdmode_pkg;
   typedef enum logic [1:0] {
      MODE_ARRAY  = 2'b00,
      MODE_STATUS = 2'b01,
      MODE_ID     = 2'b10,
      MODE_CFI    = 2'b11
   } rd_mode_t;
   typedef enum logic [1:0] {
      RESP_OKAY   = 2'b00,
      RESP_SLVERR = 2'b10
   } axi_resp_t;
endpackage

//--- rtl/flash_read_mode_control.sv
// per-partition read-mode control with wait pin and register slave
`timescale 1ns/10ps
`include "flash_rdmode_defines.svh"
module flash_read_mode_control #(
   parameter int          NP        = 8,
   parameter int          AW        = 24,
   parameter logic [15:0] MAKER_ID  = 16'h00A5, // arbitrary value
   parameter logic [15:0] DEVICE_ID = 16'h005A  // arbitrary value
) (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic [5:0]                  awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [31:0]                 wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   output flash_rdmode_pkg::axi_resp_t      bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   input  wire logic [5:0]                  araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic [31:0]                      rdata,
   output flash_rdmode_pkg::axi_resp_t      rresp,
   output logic                             rvalid,
   input  wire logic                        rready,
   input  wire logic                        flash_clk,
   input  wire logic                        ce_n,
   input  wire logic                        oe_n,
   input  wire logic                        we_n,
   input  wire logic [AW-1:0]               flash_addr,
   input  wire logic [15:0]                 dq_in,
   input  wire logic [NP-1:0]               op_start,
   input  wire logic [NP-1:0]               lock_setup,
   input  wire logic [NP-1:0]               op_resume,
   input  wire logic [NP-1:0]               op_busy,
   input  wire logic [15:0]                 array_rdata,
   input  wire logic [15:0]                 status_word,
   input  wire logic [15:0]                 cfi_rdata,
   input  wire logic [15:0]                 otp_rdata,
   input  wire logic [1:0]                  lock_state,
   output logic [15:0]                      rd_data,
   output logic                             rd_valid,
   output logic                             wait_o,
   output logic                             wait_oe
);
   import flash_rdmode_pkg::*;

   localparam int PW = $clog2(NP);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   //----------------------------------------------------------------
   // pin synchronisers
   //----------------------------------------------------------------
   logic [AW+19:0] pin_m_r;
   logic [AW+19:0] pin_s_r;
   logic           lclk_d_r;
   logic           we_d_r;
   logic           rd_act_d_r;
   logic           rd_act;

   // two flops on every pin, then edge history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_m_r    <= {1'b0, 3'b111, {(AW+16){1'b0}}}; // idle pin levels, no false edge
         pin_s_r    <= {1'b0, 3'b111, {(AW+16){1'b0}}};
         lclk_d_r   <= 1'b0;
         we_d_r     <= 1'b1;
         rd_act_d_r <= 1'b0;
      end else begin
         pin_m_r    <= {flash_clk, ce_n, oe_n, we_n, flash_addr, dq_in};
         pin_s_r    <= pin_m_r;
         lclk_d_r   <= pin_s_r[AW+19];
         we_d_r     <= pin_s_r[AW+16];
         rd_act_d_r <= rd_act;
      end
   end

   logic            lclk_s;
   logic            ce_n_s;
   logic            oe_n_s;
   logic            we_n_s;
   logic [AW-1:0]   addr_s;
   logic [15:0]     dq_s;
   logic            link_rise;
   logic            cmd_stb;
   logic            rd_start;
   logic [PW-1:0]   cmd_part;
   logic [8:0]      id_ofs;

   // decoded bus events
   assign {lclk_s, ce_n_s, oe_n_s, we_n_s, addr_s, dq_s} = pin_s_r;
   assign link_rise = lclk_s & ~lclk_d_r;
   assign cmd_stb   = we_n_s & ~we_d_r & ~ce_n_s;
   assign rd_act    = ~ce_n_s & ~oe_n_s & we_n_s;
   assign rd_start  = rd_act & ~rd_act_d_r;
   assign cmd_part  = addr_s[AW-1 -: PW];
   assign id_ofs    = addr_s[8:0];

   //----------------------------------------------------------------
   // configuration registers
   //----------------------------------------------------------------
   logic [15:0] rcr_r;
   logic [15:0] ecr_r;
   logic        mux_bus_r;
   logic        aw_got_r;
   logic        w_got_r;
   logic [5:0]  aw_q_r;
   logic [31:0] w_q_r;
   logic [3:0]  ws_q_r;
   logic        wr_do;
   logic        wr_hit;

   assign wr_do  = aw_got_r & w_got_r & ~bvalid;
   assign wr_hit = aw_q_r == `OFS_CTRL || aw_q_r == `OFS_RCR || aw_q_r == `OFS_ECR
                   || aw_q_r == `OFS_MODE || aw_q_r == `OFS_RDST;

   // write address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awready  <= 1'b1;
         wready   <= 1'b1;
         aw_q_r   <= '0;
         w_q_r    <= '0;
         ws_q_r   <= '0;
      end else begin
         if (awvalid && awready) begin
            aw_got_r <= 1'b1;
            awready  <= 1'b0;
            aw_q_r   <= awaddr;
         end
         if (wvalid && wready) begin
            w_got_r <= 1'b1;
            wready  <= 1'b0;
            w_q_r   <= wdata;
            ws_q_r  <= wstrb;
         end
         if (bvalid && bready) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awready  <= 1'b1;
            wready   <= 1'b1;
         end
      end
   end

   // write response, error on unmapped offset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid <= 1'b1;
         bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // writable configuration with byte lanes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rcr_r     <= `RCR_RST;
         ecr_r     <= `ECR_RST;
         mux_bus_r <= 1'b0;
      end else if (wr_do) begin
         if (aw_q_r == `OFS_RCR) begin
            if (ws_q_r[0]) rcr_r[7:0]  <= w_q_r[7:0];
            if (ws_q_r[1]) rcr_r[15:8] <= w_q_r[15:8];
         end
         if (aw_q_r == `OFS_ECR) begin
            if (ws_q_r[0]) ecr_r[7:0]  <= w_q_r[7:0];
            if (ws_q_r[1]) ecr_r[15:8] <= w_q_r[15:8];
         end
         if (aw_q_r == `OFS_CTRL && ws_q_r[0]) mux_bus_r <= w_q_r[`CTRL_MUX];
      end
   end

   //----------------------------------------------------------------
   // per-partition read mode
   //----------------------------------------------------------------
   rd_mode_t mode_r [NP];
   logic [2*NP-1:0] mode_flat;

   // any read-mode command acts whatever the supply level
   for (genvar i = 0; i < NP; i++) begin : g_part
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            mode_r[i] <= MODE_ARRAY;
         end else if (op_start[i] || lock_setup[i] || op_resume[i]) begin
            mode_r[i] <= MODE_STATUS;
         end else if (cmd_stb && cmd_part == PW'(i)) begin
            case (dq_s)
               `CMD_ARRAY:  mode_r[i] <= MODE_ARRAY;
               `CMD_STATUS: mode_r[i] <= MODE_STATUS;
               `CMD_ID:     mode_r[i] <= MODE_ID;
               `CMD_CFI:    mode_r[i] <= MODE_CFI;
               default:     mode_r[i] <= mode_r[i];
            endcase
         end
      end
      assign mode_flat[2*i +: 2] = mode_r[i];
   end

   AST_EVENT_STATUS: assert property (op_start[0] |=> mode_r[0] == MODE_STATUS)
      else $error("program start did not force status mode");
   AST_RESUME_STATUS: assert property (op_resume[NP-1] |=> mode_r[NP-1] == MODE_STATUS)
      else $error("resume did not return partition to status");
   AST_RESET_ARRAY: assert property ($rose(aresetn) |-> mode_r[0] == MODE_ARRAY)
      else $error("partition not in array mode after reset");

   sequence s_cmd(logic [15:0] code);
      cmd_stb && dq_s == code && !op_start[cmd_part] && !lock_setup[cmd_part] && !op_resume[cmd_part];
   endsequence
   AST_ID_CMD: assert property (s_cmd(`CMD_ID) |=> mode_r[$past(cmd_part)] == MODE_ID)
      else $error("identification command not applied");
   AST_CFI_CMD: assert property (s_cmd(`CMD_CFI) |=> mode_r[$past(cmd_part)] == MODE_CFI)
      else $error("query command not applied");
   AST_OTHER_KEPT: assert property (cmd_stb && cmd_part != '0 && !op_start[0] && !lock_setup[0]
                                    && !op_resume[0] |=> $stable(mode_r[0]))
      else $error("command changed another partition");

   //----------------------------------------------------------------
   // read path
   //----------------------------------------------------------------
   rd_mode_t   rd_mode;
   logic       rd_busy;
   logic       data_ok;
   logic [3:0] lat_cnt_r;
   logic [3:0] lat_code;
   logic       sync_rd;
   logic       lat_ok;
   logic       wait_ok;
   logic [15:0] status_hold_r;
   logic [15:0] id_data;
   logic [15:0] rd_nxt;

   assign rd_mode  = mode_r[cmd_part];
   assign rd_busy  = op_busy[cmd_part];
   assign data_ok  = rd_mode == MODE_STATUS || !rd_busy;
   assign sync_rd  = ~rcr_r[`RCR_MODE];
   assign lat_code = rcr_r[`RCR_LAT_HI:`RCR_LAT_LO];
   assign lat_ok   = !sync_rd || lat_cnt_r >= lat_code;
   assign wait_ok  = !sync_rd || {1'b0, lat_cnt_r} + {4'h0, rcr_r[`RCR_DLY]} >= {1'b0, lat_code};

   // link clock edges counted since the read began
   always_ff @(posedge aclk) begin
      if (!aresetn || rd_start) begin
         lat_cnt_r <= '0;
      end else if (rd_act && link_rise && lat_cnt_r != 4'hF) begin
         lat_cnt_r <= lat_cnt_r + 4'h1;
      end
   end

   // status captured only when a read select begins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_hold_r <= '0;
      end else if (rd_start) begin
         status_hold_r <= status_word;
      end
   end

   sequence s_read_held;
      (rd_act && !rd_start) ##1 rd_act;
   endsequence
   AST_STATUS_HOLD: assert property (s_read_held |-> $stable(status_hold_r))
      else $error("status changed without a select toggle");

   // identification space decode
   always_comb begin
      id_data = 16'h0000;
      if (id_ofs == `ID_MAKER) id_data = MAKER_ID;
      else if (id_ofs == `ID_DEV) id_data = DEVICE_ID;
      else if (id_ofs == `ID_LOCK) id_data = {14'h0000, lock_state};
      else if (id_ofs == `ID_RCR) id_data = rcr_r;
      else if (id_ofs == `ID_ECR) id_data = ecr_r;
      else if (id_ofs >= `ID_OTPL0 && id_ofs <= `ID_OTP_END) id_data = otp_rdata;
   end

   // data select by mode of the read partition
   always_comb begin
      unique case (rd_mode)
         MODE_ARRAY:  rd_nxt = array_rdata;
         MODE_STATUS: rd_nxt = status_hold_r;
         MODE_ID:     rd_nxt = id_data;
         MODE_CFI:    rd_nxt = cfi_rdata;
      endcase
   end

   // registered read data and validity
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_data  <= '0;
         rd_valid <= 1'b0;
      end else begin
         rd_data  <= rd_act ? rd_nxt : 16'h0000;
         rd_valid <= rd_act && data_ok && lat_ok;
      end
   end

   AST_BUSY_INVALID: assert property (rd_act && rd_busy && rd_mode != MODE_STATUS |=> !rd_valid)
      else $error("busy partition presented valid data");

   //----------------------------------------------------------------
   // wait pin
   //----------------------------------------------------------------
   logic wait_asrt;
   logic wait_drv;

   assign wait_asrt = sync_rd && rd_act && !(data_ok && wait_ok);
   assign wait_drv  = !ce_n_s && (mux_bus_r || rd_act);

   // level moves on link edges only during sync-mode reads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_o  <= 1'b1;
         wait_oe <= 1'b0;
      end else begin
         wait_oe <= wait_drv;
         if (!sync_rd || link_rise || !rd_act) begin
            wait_o <= wait_asrt ? rcr_r[`RCR_POL] : ~rcr_r[`RCR_POL];
         end
      end
   end

   AST_WAIT_DESEL: assert property (ce_n_s |=> !wait_oe)
      else $error("wait driven while deselected");
   AST_WAIT_ASYNC: assert property (!sync_rd && rd_act |=> wait_o == !$past(rcr_r[`RCR_POL]))
      else $error("wait asserted in async read");
   AST_WAIT_EDGE: assert property (sync_rd && rd_act && !link_rise |=> $stable(wait_o))
      else $error("wait moved without link edge");

   //----------------------------------------------------------------
   // register reads
   //----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= RESP_OKAY;
         case (araddr)
            `OFS_CTRL: rdata <= {31'h00000000, mux_bus_r};
            `OFS_RCR:  rdata <= {16'h0000, rcr_r};
            `OFS_ECR:  rdata <= {16'h0000, ecr_r};
            `OFS_MODE: rdata <= 32'(mode_flat);
            `OFS_RDST: rdata <= {24'h000000, rd_valid, wait_asrt, rd_busy, 1'b0, lat_cnt_r};
            default: begin
               rdata <= '0;
               rresp <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

endmodule // flash_read_mode_control

//--- testbench/host_bus.sv
// host model driving the parallel flash bus pins
`timescale 1ns/10ps
module host_bus #(
   parameter int AW = 24
) (
   input  wire logic          aclk,
   output logic               flash_clk,
   output logic               ce_n,
   output logic               oe_n,
   output logic               we_n,
   output logic [AW-1:0]      flash_addr,
   output logic [15:0]        dq_in,
   input  wire logic [15:0]   rd_data,
   input  wire logic          rd_valid,
   input  wire logic          wait_o,
   input  wire logic          wait_oe
);
   logic        frame;
   logic [15:0] d_s;
   logic        v_s, v1_s, w1_s, w2_s, oe1_s, z_s;

   // idle bus at time zero
   initial begin
      frame = 1'b0;
      ce_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      flash_addr = '0;
      dq_in = 16'h5A5A;
   end

   // link clock toggles only inside read frames, offset from aclk edges
   initial begin
      flash_clk = 1'b0;
      #1;
      forever begin
         #62.5;
         flash_clk <= frame ? ~flash_clk : 1'b0;
      end
   end

   // single command write, held across the sync delay
   task automatic cmd(input logic [2:0] p, input logic [15:0] c);
      @(posedge aclk);
      flash_addr <= {p, {(AW-3){1'b0}}};
      dq_in <= c;
      ce_n <= 1'b0;
      we_n <= 1'b0;
      repeat (4) @(posedge aclk);
      we_n <= 1'b1;
      repeat (5) @(posedge aclk);
      ce_n <= 1'b1;
      dq_in <= ~c;
      flash_addr <= ~flash_addr;
   endtask

   // read frame with an early and a late sample, then deselect
   task automatic rd(input logic [AW-1:0] a, input logic oe, input int n1, input int n2);
      @(posedge aclk);
      flash_addr <= a;
      ce_n <= 1'b0;
      oe_n <= oe;
      frame <= ~oe;
      repeat (n1) @(posedge aclk);
      w1_s = wait_o;
      v1_s = rd_valid;
      oe1_s = wait_oe;
      repeat (n2) @(posedge aclk);
      d_s = rd_data;
      v_s = rd_valid;
      w2_s = wait_o;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      frame <= 1'b0;
      flash_addr <= ~a;
      repeat (4) @(posedge aclk);
      z_s = wait_oe;
   endtask
endmodule // host_bus

//--- testbench/testbench.sv
// self-checking bench for the read-mode command block
`timescale 1ns/10ps
`include "flash_rdmode_defines.svh"
`define CHK(g, e) check(32'(g), 32'(e))
module testbench;
   import flash_rdmode_pkg::*;
   typedef struct {logic [2:0] p; logic [15:0] c; rd_mode_t m;} row_t;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [5:0]  awaddr = '0, araddr = '0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0, rdat, rdata;
   logic [3:0]  wstrb = '0;
   axi_resp_t   bresp, rresp, rs;
   logic        awready, wready, bvalid, arready, rvalid, flash_clk, ce_n, oe_n, we_n;
   logic [23:0] flash_addr;
   logic [15:0] dq_in, rd_data, exp_mode = '0;
   logic [15:0] array_rdata = 16'h1234, status_word = 16'h0080, cfi_rdata = 16'h0051, otp_rdata = 16'hC3C3;
   logic [7:0]  op_start = '0, lock_setup = '0, op_resume = '0, op_busy = '0;
   logic [1:0]  lock_state = 2'b10;
   logic        rd_valid, wait_o, wait_oe;
   int          num_errors = 0, total_checks = 0, cycles = 0;
   row_t        rows [9] = '{'{3'd0, `CMD_ARRAY, MODE_ARRAY}, '{3'd1, `CMD_STATUS, MODE_STATUS},
      '{3'd2, `CMD_ID, MODE_ID}, '{3'd3, `CMD_CFI, MODE_CFI}, '{3'd4, 16'h1234, MODE_ARRAY},
      '{3'd5, `CMD_STATUS, MODE_STATUS}, '{3'd5, `CMD_ARRAY, MODE_ARRAY},
      '{3'd6, `CMD_ID, MODE_ID}, '{3'd6, `CMD_STATUS, MODE_STATUS}};
   logic [8:0]  id_ofs [6] = '{`ID_MAKER, `ID_DEV, `ID_LOCK, `ID_RCR, `ID_ECR, `ID_OTPL0};
   logic [15:0] id_exp [6] = '{16'h00C6, 16'h006C, 16'h0002, `RCR_RST, `ECR_RST, 16'hC3C3};
   rd_mode_t    bm [3] = '{MODE_ARRAY, MODE_ID, MODE_CFI};
   logic [15:0] bc [3] = '{`CMD_ARRAY, `CMD_ID, `CMD_CFI};

   // bus clock
   always #5 aclk = ~aclk;

   // identity codes are arbitrary values
   flash_read_mode_control #(.MAKER_ID(16'h00C6), .DEVICE_ID(16'h006C)) u_flash_read_mode_control (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .flash_clk, .ce_n, .oe_n, .we_n, .flash_addr, .dq_in, .op_start, .lock_setup, .op_resume,
      .op_busy, .array_rdata, .status_word, .cfi_rdata, .otp_rdata, .lock_state, .rd_data,
      .rd_valid, .wait_o, .wait_oe);

   host_bus u_host_bus (.aclk, .flash_clk, .ce_n, .oe_n, .we_n, .flash_addr, .dq_in, .rd_data,
      .rd_valid, .wait_o, .wait_oe);

   // compare and count
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // verdict and end of run
   task summarize;
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // register write, address and data released as each is taken
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic a_ok, w_ok;
      a_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(a_ok && w_ok)) begin
         @(posedge aclk);
         a_ok = a_ok | (awready === 1'b1);
         w_ok = w_ok | (wready === 1'b1);
         awvalid <= !a_ok;
         wvalid <= !w_ok;
      end
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask

   // register read
   task automatic rd(input logic [5:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rdat = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   // hang guard
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         summarize;
      end
   end

   // main sequence
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`OFS_RCR);
      `CHK(rdat, `RCR_RST);
      `CHK(rdat[`RCR_POL], 1'b0);
      rd(`OFS_ECR);
      `CHK(rdat, `ECR_RST);
      rd(`OFS_MODE);
      `CHK(rdat, 16'h0000);
      rd(6'h14);
      `CHK(rs, RESP_SLVERR);
      wr(6'h14, 32'h0000_0000);
      `CHK(rs, RESP_SLVERR);
      foreach (rows[i]) begin
         u_host_bus.cmd(rows[i].p, rows[i].c);
         exp_mode[2*rows[i].p +: 2] = rows[i].m;
         rd(`OFS_MODE);
         `CHK(rdat, exp_mode);
      end
      for (int i = 0; i < 6; i++) begin
         u_host_bus.rd({15'h2000, id_ofs[i]}, 1'b0, 4, 2);
         `CHK(u_host_bus.d_s, id_exp[i]);
      end
      fork
         u_host_bus.rd(24'h200000, 1'b0, 4, 8);
         begin
            repeat (8) @(posedge aclk);
            status_word <= 16'h0000;
         end
      join
      `CHK(u_host_bus.d_s, 16'h0080);
      `CHK(u_host_bus.d_s[7], 1'b1);
      `CHK({u_host_bus.oe1_s, u_host_bus.w1_s, u_host_bus.z_s}, 3'b110);
      u_host_bus.rd(24'h200000, 1'b0, 4, 2);
      `CHK(u_host_bus.d_s, 16'h0000);
      u_host_bus.cmd(3'd0, `CMD_ARRAY);
      u_host_bus.rd(24'h000000, 1'b0, 4, 2);
      `CHK({u_host_bus.d_s, u_host_bus.v_s}, {16'h1234, 1'b1});
      @(posedge aclk);
      op_start <= 8'h05;
      lock_setup <= 8'h08;
      @(posedge aclk);
      op_start <= 8'h00;
      lock_setup <= 8'h00;
      exp_mode[7:0] = 8'h55;
      rd(`OFS_MODE);
      `CHK(rdat, exp_mode);
      op_busy <= 8'h02;
      for (int i = 0; i < 3; i++) begin
         u_host_bus.cmd(3'd1, bc[i]);
         u_host_bus.rd(24'h200000, 1'b0, 4, 2);
         `CHK(u_host_bus.v_s, 1'b0);
         rd(`OFS_MODE);
         `CHK(rdat[3:2], bm[i]);
      end
      @(posedge aclk);
      op_busy <= 8'h00;
      u_host_bus.rd(24'h200000, 1'b0, 4, 2);
      `CHK(u_host_bus.v_s, 1'b1);
      @(posedge aclk);
      op_resume <= 8'h82;
      @(posedge aclk);
      op_resume <= 8'h00;
      rd(`OFS_MODE);
      `CHK(rdat[3:2], MODE_STATUS);
      `CHK(rdat[15:14], MODE_STATUS);
      u_host_bus.cmd(3'd0, `CMD_ARRAY);
      for (int pol = 0; pol < 2; pol++) begin
         wr(`OFS_RCR, 32'h0000_1800 | (pol << 10));
         `CHK(rs, RESP_OKAY);
         u_host_bus.rd(24'h000000, 1'b0, 24, 36);
         `CHK({u_host_bus.w1_s, u_host_bus.v1_s}, {pol[0], 1'b0});
         `CHK({u_host_bus.w2_s, u_host_bus.v_s}, {~pol[0], 1'b1});
      end
      wr(`OFS_RCR, `RCR_RST);
      wr(`OFS_CTRL, 32'h0000_0001);
      u_host_bus.rd(24'h000000, 1'b1, 4, 2);
      `CHK({u_host_bus.oe1_s, u_host_bus.w1_s}, 2'b11);
      wr(`OFS_CTRL, 32'h0000_0000);
      u_host_bus.rd(24'h000000, 1'b1, 4, 2);
      `CHK(u_host_bus.oe1_s, 1'b0);
      summarize;
   end
endmodule // testbench
